//--- pgl_pkg.sv
// package for the pam4 gray lane loopback attachment block
// assumes a 100 mhz aclk and an axi4-lite register bus with 32-bit data
package pgl_pkg;

  // lane counts: eight nrz client lanes folded onto four pam4 lanes
  localparam int unsigned CLIENT_LANES = 8;
  localparam int unsigned PAM4_LANES   = 4;
  localparam int unsigned SYM_W        = 2;

  // register byte offsets
  localparam logic [5:0] CTRL_OFFS       = 6'h00;
  localparam logic [5:0] LOCAL_ABIL_OFFS = 6'h04;
  localparam logic [5:0] FAR_LOW_OFFS    = 6'h08;
  localparam logic [5:0] FAR_HIGH_OFFS   = 6'h0c;
  localparam logic [5:0] STATUS_OFFS     = 6'h10;

  // field positions
  localparam int unsigned LOCAL_LOOP_BIT    = 0;
  localparam int unsigned REMOTE_LOOP_BIT   = 1;
  localparam int unsigned LOCAL_ABIL_BIT    = 0;
  localparam int unsigned FAR_ABIL_BIT      = 15;
  localparam int unsigned STAT_LINK_BIT     = 0;
  localparam int unsigned STAT_CDR_BIT      = 1;
  localparam int unsigned STAT_LOWER_OK_BIT = 2;
  localparam int unsigned STAT_PATTERN_BIT  = 3;

  // reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // cumulative delay budget, four stages, tx plus rx
  localparam int unsigned DELAY_LOW_BITS  = 18432;
  localparam int unsigned DELAY_HIGH_BITS = 36864;
  localparam int unsigned DELAY_MAX_PS    = 92160;
  localparam int unsigned CLK_PERIOD_PS   = 10000;
  localparam int unsigned STAGES          = 4;
  // budget per stage per direction, in aclk cycles, rounded down
  localparam int unsigned DELAY_MAX_CYC   = DELAY_MAX_PS / (STAGES * 2 * CLK_PERIOD_PS);
  // two sync flops, one edge flop, one output flop
  localparam int unsigned PATH_LATENCY_CYC = 4;

endpackage

//--- pgl_lane_pma.sv
// lane attachment logic: bit mux, gray mapping, loopbacks, signal indication
// assumes lane clock and lane data arrive from outside the aclk domain;
// lane data is stable around the rising edge of lane_clk
`timescale 1ns/1ns
//
// Notes on behaviour
// - four stages together stay within delay budget; only this stage is checked, against the whole budget
// - output lane rate is m/n input rate
// - pam4 symbol rate is half bit rate
// - output lanes may be clocked independently
// - tx pairs first bit high, gray encode
// - rx gray decode, first bit left
// - lower signal feeds signal indication logic
// - local loopback returns tx bits to client
// - local loopback keeps tx muxing toward lower
// - control bit enters and leaves local loopback
// - read-only local loopback ability bit
// - remote loopback returns rx symbols outward
// - remote loopback keeps rx muxing toward client
// - control bit enters and leaves remote loopback
// - read-only remote loopback ability bits, both rates
// - remote loopback placed next to medium lanes
// - test patterns optional, reported absent
// - lane ordering fixed while streams valid
// - every coding sublayer lane bit carried through
module pgl_lane_pma (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // lane clock shared by client and lower side
  input  wire logic        lane_clk,
  // client side: one bit per coding_sublayer_lane each lane clock
  input  wire logic [7:0]  client_tx_bits,
  output logic [7:0]       client_rx_bits,
  output logic             client_link_ok,
  // lower side: one pam4 symbol per lane each lane clock
  output logic [7:0]       lower_tx_syms,
  input  wire logic [7:0]  lower_rx_syms,
  input  wire logic        lower_signal_ok,
  input  wire logic        lower_cdr_lock
);

  localparam int unsigned NL = pgl_pkg::PAM4_LANES;
  localparam int unsigned SW = pgl_pkg::SYM_W;

  // budget check is elaboration-time; latency is fixed by construction.
  // this stage alone, transmit plus receive, is held against the whole
  // cumulative budget of one link end; a per-stage share rounds to one cycle
  localparam bit DELAY_FITS =
    (2 * pgl_pkg::PATH_LATENCY_CYC * pgl_pkg::CLK_PERIOD_PS) <= pgl_pkg::DELAY_MAX_PS;

  logic [1:0]  ctrl_reg;
  logic [5:0]  awaddr_reg;
  logic        aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rd_hit;
  logic        wr_fire;

  logic        lclk_s1_reg;
  logic        lclk_s2_reg;
  logic        lclk_s3_reg;
  logic        lane_tick;
  logic [7:0]  txb_s1_reg;
  logic [7:0]  txb_s2_reg;
  logic [7:0]  rxs_s1_reg;
  logic [7:0]  rxs_s2_reg;
  logic [1:0]  stat_s1_reg;
  logic [1:0]  stat_s2_reg;
  logic [7:0]  tx_sym_next;
  logic [7:0]  rx_bits_next;
  logic [7:0]  tx_sym_reg;
  logic [7:0]  rx_bits_reg;
  logic        link_reg;

  // ---------------- register bus ----------------

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  // write address flag: set when the address is taken, cleared as the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // write address latch; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awaddr_reg <= s_axi_awaddr;
    end
  end

  // write data flag: set when the data is taken, cleared as the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // write data and strobe latch, held until the write fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // control register: loopback enables, cleared at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= pgl_pkg::CTRL_RESET;
    end else if (wr_fire && awaddr_reg[5:2] == pgl_pkg::CTRL_OFFS[5:2] && wstrb_reg[0]) begin
      ctrl_reg[pgl_pkg::LOCAL_LOOP_BIT]  <= wdata_reg[pgl_pkg::LOCAL_LOOP_BIT];
      ctrl_reg[pgl_pkg::REMOTE_LOOP_BIT] <= wdata_reg[pgl_pkg::REMOTE_LOOP_BIT];
    end
  end

  // write response valid: raised once both halves are held, dropped on bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // write response code: only the control word is writable, all others refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_reg <= pgl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bresp_reg <= (awaddr_reg[5:2] == pgl_pkg::CTRL_OFFS[5:2]) ? pgl_pkg::RESP_OKAY
                                                               : pgl_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;

  // read decode
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_hit     = 1'b1;
    unique case (s_axi_araddr[5:2])
      pgl_pkg::CTRL_OFFS[5:2]:       rdata_next[1:0] = ctrl_reg;
      pgl_pkg::LOCAL_ABIL_OFFS[5:2]: rdata_next[pgl_pkg::LOCAL_ABIL_BIT] = 1'b1;
      pgl_pkg::FAR_LOW_OFFS[5:2]:    rdata_next[pgl_pkg::FAR_ABIL_BIT] = 1'b1;
      pgl_pkg::FAR_HIGH_OFFS[5:2]:   rdata_next[pgl_pkg::FAR_ABIL_BIT] = 1'b1;
      pgl_pkg::STATUS_OFFS[5:2]: begin
        rdata_next[pgl_pkg::STAT_LINK_BIT]     = link_reg;
        rdata_next[pgl_pkg::STAT_CDR_BIT]      = stat_s2_reg[1];
        rdata_next[pgl_pkg::STAT_LOWER_OK_BIT] = stat_s2_reg[0];
        rdata_next[pgl_pkg::STAT_PATTERN_BIT]  = 1'b0;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read answer valid one cycle after the address is taken, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // read word and code latched as the address is taken, steady while valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= pgl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rdata_reg <= rdata_next;
      rresp_reg <= rd_hit ? pgl_pkg::RESP_OKAY : pgl_pkg::RESP_SLVERR;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ---------------- lane side ----------------

  // lane clock passes two flops, a third keeps the last value for the edge test
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lclk_s1_reg <= 1'b0;
      lclk_s2_reg <= 1'b0;
      lclk_s3_reg <= 1'b0;
    end else begin
      lclk_s1_reg <= lane_clk;
      lclk_s2_reg <= lclk_s1_reg;
      lclk_s3_reg <= lclk_s2_reg;
    end
  end

  // client bits pass two flops; they stand still around a lane edge, so the
  // copy read at the detected edge is whole
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txb_s1_reg <= 8'h00;
      txb_s2_reg <= 8'h00;
    end else begin
      txb_s1_reg <= client_tx_bits;
      txb_s2_reg <= txb_s1_reg;
    end
  end

  // received symbols pass two flops, the same delay as the lane clock copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxs_s1_reg <= 8'h00;
      rxs_s2_reg <= 8'h00;
    end else begin
      rxs_s1_reg <= lower_rx_syms;
      rxs_s2_reg <= rxs_s1_reg;
    end
  end

  // lower status levels pass two flops: bit 1 recovery lock, bit 0 signal ok
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_s1_reg <= 2'h0;
      stat_s2_reg <= 2'h0;
    end else begin
      stat_s1_reg <= {lower_cdr_lock, lower_signal_ok};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // one symbol per lane per lane clock: two bits in, one symbol out
  assign lane_tick = lclk_s2_reg && !lclk_s3_reg;

  // per lane gray mapping; client lane 2i always arrives first on lane i
  // gray map, first bit high: 00 -> 0, 01 -> 1, 11 -> 2, 10 -> 3
  for (genvar i = 0; i < NL; i++) begin : g_lane
    logic a_bit;
    logic b_bit;
    logic [SW-1:0] rx_sym;
    assign a_bit = txb_s2_reg[2*i];
    assign b_bit = txb_s2_reg[2*i+1];
    assign rx_sym = rxs_s2_reg[SW*i +: SW];
    always_comb begin
      // remote loopback sends the received symbol straight back out
      if (ctrl_reg[pgl_pkg::REMOTE_LOOP_BIT]) begin
        tx_sym_next[SW*i +: SW] = rx_sym;
      end else begin
        tx_sym_next[SW*i +: SW] = {a_bit, a_bit ^ b_bit};
      end
      // local loopback returns client bits, one for one
      if (ctrl_reg[pgl_pkg::LOCAL_LOOP_BIT]) begin
        rx_bits_next[2*i]   = a_bit;
        rx_bits_next[2*i+1] = b_bit;
      end else begin
        rx_bits_next[2*i]   = rx_sym[1];
        rx_bits_next[2*i+1] = rx_sym[1] ^ rx_sym[0];
      end
    end
  end

  // all lanes share the one lane clock here, which independent clocking allows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sym_reg <= 8'h00;
    end else if (lane_tick) begin
      tx_sym_reg <= tx_sym_next;
    end
  end

  // client receive bits move on the same lane tick, one bit per client lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bits_reg <= 8'h00;
    end else if (lane_tick) begin
      rx_bits_reg <= rx_bits_next;
    end
  end

  // signal indication logic: lower signal and recovery lock, or local loopback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_reg <= 1'b0;
    end else begin
      link_reg <= (stat_s2_reg[0] && stat_s2_reg[1])
                  || ctrl_reg[pgl_pkg::LOCAL_LOOP_BIT];
    end
  end

  assign lower_tx_syms  = tx_sym_reg;
  assign client_rx_bits = rx_bits_reg;
  assign client_link_ok = link_reg && DELAY_FITS;

endmodule

//--- pgl_lane_pma_properties.sv
// checker for the pam4 lane block: register bus timing and link status
// bound to every pgl_lane_pma instance, sees its ports only
`timescale 1ns/1ns
module pgl_lane_pma_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus, write side
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // register bus, read side
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // link status
  input wire logic        lower_signal_ok,
  input wire logic        lower_cdr_lock,
  input wire logic        client_link_ok
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data of a write taken together, and a read request taken
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves are held one cycle, the answer stands from the cycle after
  write_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  ctrl_write_ok_a: assert property (wr_taken ##0 s_axi_awaddr == pgl_pkg::CTRL_OFFS
    |=> ##1 s_axi_bresp == pgl_pkg::RESP_OKAY) else $error("control write refused");
  ro_write_err_a: assert property (wr_taken ##0 s_axi_awaddr != pgl_pkg::CTRL_OFFS
    |=> ##1 s_axi_bresp == pgl_pkg::RESP_SLVERR) else $error("read-only write accepted");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  unmapped_read_a: assert property (rd_taken ##0 s_axi_araddr[5:2] > pgl_pkg::STATUS_OFFS[5:2]
    |=> s_axi_rresp == pgl_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  link_up_a: assert property ((lower_signal_ok && lower_cdr_lock) [*5] |-> client_link_ok)
    else $error("link status not reported");
endmodule

bind pgl_lane_pma pgl_lane_pma_props u_props (.*);

//--- pgl_lower_model.sv
// far-side model: free-running lane clock and pam4 symbols from below
// the bench commands link loss through link_en
`timescale 1ns/1ns
module pgl_lower_model (
  // command from the bench
  input wire logic link_en,
  // lane side
  output logic       lane_clk,
  output logic [7:0] lower_rx_syms,
  output logic       lower_signal_ok,
  output logic       lower_cdr_lock
);
  int seed = 32'h61ba;
  // 80 ns lane clock, phase offset from aclk
  initial begin
    lane_clk = 1'b0;
    #3;
    forever #40 lane_clk = ~lane_clk;
  end
  // new symbols on the falling edge, stable around the rising one
  initial begin
    lower_rx_syms = 8'h00;
    forever @(negedge lane_clk) lower_rx_syms <= 8'($random(seed));
  end
  // signal and recovery status follow the command
  assign lower_signal_ok = link_en;
  assign lower_cdr_lock  = link_en;
endmodule

//--- pgl_lane_pma_test.sv
// self-checking bench for pgl_lane_pma with the lower-side model
// registers over axi4-lite, random client bits once per lane period
`timescale 1ns/1ns
module pgl_lane_pma_test;
  logic        aclk = 1'b0, aresetn = 1'b0, link_en = 1'b0, lc_q = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        lane_clk, lower_signal_ok, lower_cdr_lock, client_link_ok;
  logic [7:0]  client_tx_bits = 8'h0, client_rx_bits, lower_tx_syms, lower_rx_syms;
  logic [7:0]  tx_cap = 8'h0, rx_cap = 8'h0;
  logic        lane_rise = 1'b0;
  int          bad_count = 0, tests_run = 0, seed = 32'h61ba;

  always #5 aclk = ~aclk;
  pgl_lane_pma dut (.*);
  pgl_lower_model far_end (.*);

  // client bits change after a falling lane edge, captured at the rising one
  always @(posedge aclk) begin
    lc_q <= lane_clk;
    lane_rise <= !lc_q && lane_clk;
    if (lc_q && !lane_clk) client_tx_bits <= 8'($random(seed));
    if (!lc_q && lane_clk) begin
      tx_cap <= client_tx_bits;
      rx_cap <= lower_rx_syms;
    end
  end

  // expected gray symbols: lane 2i is the first bit of each pair
  function automatic logic [7:0] enc(input logic [7:0] b);
    for (int i = 0; i < 4; i++) enc[2*i +: 2] = {b[2*i], b[2*i] ^ b[2*i+1]};
  endfunction
  function automatic logic [7:0] dec(input logic [7:0] s);
    for (int i = 0; i < 4; i++) dec[2*i +: 2] = {s[2*i+1] ^ s[2*i], s[2*i+1]};
  endfunction

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // one write or read; handshakes sampled mid-cycle, released after the edge
  task bus(input bit w, input logic [5:0] a, input logic [31:0] d,
           input logic [1:0] er, input logic [31:0] ed);
    int n;
    logic ta, tw, tr, done;
    done = 1'b0;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      done = w ? s_axi_bvalid : s_axi_rvalid;
      if (done && w) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      if (done && !w) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      if (done && !w) chk("rdata", s_axi_rdata, ed);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (done) begin s_axi_bready <= 1'b0; s_axi_rready <= 1'b0; end
    end
    if (!done) begin bad_count++; summarize; end
  endtask

  // next lane rise, outputs settled, both directions and link compared
  task lane(input logic [1:0] m);
    int n;
    @(posedge aclk);
    link_en <= 1'($random(seed));
    for (n = 0; n < 20 && !lane_rise; n++) @(negedge aclk);
    if (n == 20) begin bad_count++; summarize; end
    repeat (6) @(negedge aclk);
    chk("tx_syms", {24'h0, lower_tx_syms}, {24'h0, m[1] ? rx_cap : enc(tx_cap)});
    chk("rx_bits", {24'h0, client_rx_bits}, {24'h0, m[0] ? tx_cap : dec(rx_cap)});
    chk("link_ok", {31'h0, client_link_ok}, {31'h0, link_en | m[0]});
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b0, pgl_pkg::CTRL_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h0);
    bus(1'b0, pgl_pkg::LOCAL_ABIL_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h1);
    bus(1'b0, pgl_pkg::FAR_LOW_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h8000);
    bus(1'b0, pgl_pkg::FAR_HIGH_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h8000);
    bus(1'b0, 6'h14, 32'h0, pgl_pkg::RESP_SLVERR, 32'h0);
    bus(1'b1, pgl_pkg::LOCAL_ABIL_OFFS, 32'hffffffff, pgl_pkg::RESP_SLVERR, 32'h0);
    bus(1'b0, pgl_pkg::LOCAL_ABIL_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h1);
    // every loopback combination, then back to plain multiplexing
    for (int m = 0; m < 5; m++) begin
      bus(1'b1, pgl_pkg::CTRL_OFFS, {30'h0, m[1:0]}, pgl_pkg::RESP_OKAY, 32'h0);
      bus(1'b0, pgl_pkg::CTRL_OFFS, 32'h0, pgl_pkg::RESP_OKAY, {30'h0, m[1:0]});
      repeat (8) lane(m[1:0]);
    end
    @(posedge aclk);
    link_en <= 1'b1;
    repeat (8) @(posedge aclk);
    bus(1'b0, pgl_pkg::STATUS_OFFS, 32'h0, pgl_pkg::RESP_OKAY, 32'h7);
    summarize;
  end
endmodule
